// ===== core/ahbp_port.sv
// Notes on behaviour
// - Output-hold low drives bus always; high drives only during read strobe.
// - Writing 0x0000010 to address 14 selects 16-bit bus.
// - In 16-bit mode accesses come as two same-type strobes.
// - First half-word access is the low half, second the high half.
// - Top four bits of high half ignored on write, zero on read.
// - Last FIFO word: empty rises after first half-word read.
// - Hits ignored 27 ns after master reset rise, 13 ns after fall.
// - Hits ignored 60 ns after partial reset rise, 13 ns after fall.
// - Chip select, read and write strobes active low; access needs select.
// - One active-high empty output per interface FIFO.
`timescale 1ns/10ps
`default_nettype none
module ahbp_port #(
  parameter int DATA_W   = ahbp_pkg::DATA_W,
  parameter int NUM_HITS = ahbp_pkg::NUM_HITS
) (
  input  wire logic                REF_CLK_IN,
  input  wire logic                RST_IN,
  input  wire logic                CHIP_SELECT_N_IN,
  input  wire logic                READ_STROBE_N_IN,
  input  wire logic                WRITE_STROBE_N_IN,
  input  wire logic                OUTPUT_HOLD_N_IN,
  input  wire logic [3:0]          ADDR_IN,
  input  wire logic [DATA_W-1:0]   DATA_IN,
  output logic      [DATA_W-1:0]   DATA_OUT,
  output logic                     DATA_OE_OUT,
  input  wire logic [DATA_W-1:0]   FIFO_A_WORD_IN,
  input  wire logic                FIFO_A_EMPTY_IN,
  output logic                     FIFO_A_POP_OUT,
  output logic                     FIFO_A_EMPTY_OUT,
  input  wire logic [DATA_W-1:0]   FIFO_B_WORD_IN,
  input  wire logic                FIFO_B_EMPTY_IN,
  output logic                     FIFO_B_POP_OUT,
  output logic                     FIFO_B_EMPTY_OUT,
  output logic                     BUS16_OUT,
  input  wire logic                MASTER_RESET_IN,
  input  wire logic                PARTIAL_RESET_IN,
  input  wire logic [NUM_HITS-1:0] HIT_IN,
  output logic      [NUM_HITS-1:0] HIT_OUT
);

  localparam int HALF_W = ahbp_pkg::HALF_W;
  localparam int UP_W   = DATA_W - HALF_W;
  localparam int SYNC_W = 6 + 4 + DATA_W + NUM_HITS;

  // Pin synchroniser
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] next_sync1;

  always_comb begin
    next_sync1 = {CHIP_SELECT_N_IN, READ_STROBE_N_IN, WRITE_STROBE_N_IN, OUTPUT_HOLD_N_IN,
                  MASTER_RESET_IN, PARTIAL_RESET_IN, ADDR_IN, DATA_IN, HIT_IN};
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync1 <= {4'hF, {(SYNC_W-4){1'b0}}};
      sync2 <= {4'hF, {(SYNC_W-4){1'b0}}};
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end

  logic                cs_n;
  logic                rd_n;
  logic                wr_n;
  logic                hold_n;
  logic [3:0]          addr;
  logic [DATA_W-1:0]   wdata;
  logic [NUM_HITS-1:0] hits;

  ahbp_hit_if hif ();

  assign {cs_n, rd_n, wr_n, hold_n, hif.master_rst, hif.partial_rst, addr, wdata, hits} = sync2;

  ahbp_hit_gate u_gate (
    .clk (REF_CLK_IN),
    .rst (RST_IN),
    .hif (hif)
  );

  // Bus state
  logic [DATA_W-1:0]    regs [ahbp_pkg::NUM_REGS];
  logic [DATA_W-1:0]    next_regs [ahbp_pkg::NUM_REGS];
  ahbp_pkg::ahbp_half_t half;
  ahbp_pkg::ahbp_half_t next_half;
  logic [DATA_W-1:0]    hold_word;
  logic [DATA_W-1:0]    next_hold_word;
  logic                 bus16;
  logic                 next_bus16;
  logic [DATA_W-1:0]    next_dout;
  logic                 next_oe;
  logic                 next_pop_a;
  logic                 next_pop_b;
  logic                 rd_prev;
  logic                 wr_prev;
  logic [NUM_HITS-1:0]  hit_prev;
  logic [NUM_HITS-1:0]  next_hit;
  logic                 rd_start;
  logic                 wr_done;
  logic [DATA_W-1:0]    src_word;
  logic [DATA_W-1:0]    full_wr;
  logic                 wr_full;

  assign rd_start = !cs_n && rd_prev && !rd_n;
  assign wr_done  = !cs_n && !wr_prev && wr_n;

  always_comb begin
    next_regs      = regs;
    next_half      = half;
    next_hold_word = hold_word;
    next_bus16     = bus16;
    next_dout      = DATA_OUT;
    next_pop_a     = 1'b0;
    next_pop_b     = 1'b0;
    full_wr        = wdata;
    wr_full        = 1'b0;
    src_word       = regs[addr];
    if (addr == ahbp_pkg::ADDR_FIFO_A) begin
      src_word = FIFO_A_WORD_IN;
    end else if (addr == ahbp_pkg::ADDR_FIFO_B) begin
      src_word = FIFO_B_WORD_IN;
    end
    if (rd_start) begin
      if (bus16 && half == ahbp_pkg::HALF_HIGH_RD) begin
        // Second half comes from the held word, no new pop
        next_dout = {{(DATA_W-HALF_W){1'b0}}, 4'h0, hold_word[DATA_W-1:HALF_W]};
        next_half = ahbp_pkg::HALF_LOW;
      end else begin
        // Popping on the first half lets empty rise before the pair ends
        next_pop_a = (addr == ahbp_pkg::ADDR_FIFO_A) && !FIFO_A_EMPTY_IN;
        next_pop_b = (addr == ahbp_pkg::ADDR_FIFO_B) && !FIFO_B_EMPTY_IN;
        if (bus16) begin
          next_hold_word = src_word;
          next_dout      = {{UP_W{1'b0}}, src_word[HALF_W-1:0]};
          next_half      = ahbp_pkg::HALF_HIGH_RD;
        end else begin
          next_dout = src_word;
        end
      end
    end else if (wr_done) begin
      if (!bus16) begin
        wr_full = 1'b1;
      end else if (half == ahbp_pkg::HALF_HIGH_WR) begin
        full_wr   = {wdata[UP_W-1:0], hold_word[HALF_W-1:0]};
        wr_full   = 1'b1;
        next_half = ahbp_pkg::HALF_LOW;
      end else begin
        next_hold_word = {{UP_W{1'b0}}, wdata[HALF_W-1:0]};
        next_half      = ahbp_pkg::HALF_HIGH_WR;
      end
    end
    if (wr_full) begin
      next_regs[addr] = full_wr;
      if (addr == ahbp_pkg::ADDR_MODE) begin
        next_bus16 = (full_wr == ahbp_pkg::MODE16_VALUE);
        next_half  = ahbp_pkg::HALF_LOW;
      end
    end
    next_oe  = !hold_n || (!cs_n && !rd_n);
    next_hit = hits & ~hit_prev & {NUM_HITS{hif.hit_ok}};
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < ahbp_pkg::NUM_REGS; i++) begin
        regs[i] <= ahbp_pkg::REG_RESET;
      end
      half             <= ahbp_pkg::HALF_LOW;
      hold_word        <= '0;
      bus16            <= 1'b0;
      DATA_OUT         <= '0;
      DATA_OE_OUT      <= 1'b0;
      FIFO_A_POP_OUT   <= 1'b0;
      FIFO_B_POP_OUT   <= 1'b0;
      FIFO_A_EMPTY_OUT <= 1'b1;
      FIFO_B_EMPTY_OUT <= 1'b1;
      BUS16_OUT        <= 1'b0;
      rd_prev          <= 1'b1;
      wr_prev          <= 1'b1;
      hit_prev         <= '0;
      HIT_OUT          <= '0;
    end else begin
      regs             <= next_regs;
      half             <= next_half;
      hold_word        <= next_hold_word;
      bus16            <= next_bus16;
      DATA_OUT         <= next_dout;
      DATA_OE_OUT      <= next_oe;
      FIFO_A_POP_OUT   <= next_pop_a;
      FIFO_B_POP_OUT   <= next_pop_b;
      FIFO_A_EMPTY_OUT <= FIFO_A_EMPTY_IN;
      FIFO_B_EMPTY_OUT <= FIFO_B_EMPTY_IN;
      BUS16_OUT        <= next_bus16;
      rd_prev          <= rd_n;
      wr_prev          <= wr_n;
      hit_prev         <= hits;
      HIT_OUT          <= next_hit;
    end
  end

endmodule
`default_nettype wire

// ===== core/ahbp_pkg.sv
package ahbp_pkg;

  localparam int DATA_W   = 28;
  localparam int HALF_W   = 16;
  localparam int ADDR_W   = 4;
  localparam int NUM_REGS = 16;
  localparam int NUM_HITS = 9;

  localparam logic [3:0]  ADDR_MODE    = 4'hE;
  localparam logic [3:0]  ADDR_FIFO_A  = 4'h8;
  localparam logic [3:0]  ADDR_FIFO_B  = 4'h9;
  localparam logic [27:0] MODE16_VALUE = 28'h0000010;
  localparam logic [27:0] REG_RESET    = 28'h0000000;

  localparam int CLK_PERIOD_NS = 100;
  localparam int MRST_RISE_NS  = 27;
  localparam int MRST_FALL_NS  = 13;
  localparam int PRST_RISE_NS  = 60;
  localparam int PRST_FALL_NS  = 13;

  function automatic int ns_to_cyc_min(input int ns);
    int cyc;
    cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (cyc < 1) ? 1 : cyc;
  endfunction

  localparam int GATE_CNT_W    = 8;
  localparam int MRST_RISE_CYC = ns_to_cyc_min(MRST_RISE_NS);
  localparam int MRST_FALL_CYC = ns_to_cyc_min(MRST_FALL_NS);
  localparam int PRST_RISE_CYC = ns_to_cyc_min(PRST_RISE_NS);
  localparam int PRST_FALL_CYC = ns_to_cyc_min(PRST_FALL_NS);

  typedef enum logic [1:0] {
    HALF_LOW,
    HALF_HIGH_RD,
    HALF_HIGH_WR
  } ahbp_half_t;

endpackage

// ===== core/ahbp_hit_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ahbp_hit_if;
  logic master_rst;
  logic partial_rst;
  logic hit_ok;

  modport port (output master_rst, output partial_rst, input hit_ok);
  modport gate (input master_rst, input partial_rst, output hit_ok);
endinterface
`default_nettype wire

// ===== core/ahbp_hit_gate.sv
`timescale 1ns/10ps
`default_nettype none
module ahbp_hit_gate (
  input  wire logic  clk,
  input  wire logic  rst,
  ahbp_hit_if.gate   hif
);

  logic [ahbp_pkg::GATE_CNT_W-1:0] cnt;
  logic [ahbp_pkg::GATE_CNT_W-1:0] next_cnt;
  logic                            mrst_prev;
  logic                            prst_prev;

  function automatic logic [ahbp_pkg::GATE_CNT_W-1:0] at_least(
    input logic [ahbp_pkg::GATE_CNT_W-1:0] cur,
    input int                              cyc
  );
    logic [ahbp_pkg::GATE_CNT_W-1:0] v;
    v = ahbp_pkg::GATE_CNT_W'(cyc);
    return (cur > v) ? cur : v;
  endfunction

  always_comb begin
    next_cnt = cnt;
    if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
    if (hif.master_rst && !mrst_prev) begin
      next_cnt = at_least(next_cnt, ahbp_pkg::MRST_RISE_CYC);
    end
    if (!hif.master_rst && mrst_prev) begin
      next_cnt = at_least(next_cnt, ahbp_pkg::MRST_FALL_CYC);
    end
    if (hif.partial_rst && !prst_prev) begin
      next_cnt = at_least(next_cnt, ahbp_pkg::PRST_RISE_CYC);
    end
    if (!hif.partial_rst && prst_prev) begin
      next_cnt = at_least(next_cnt, ahbp_pkg::PRST_FALL_CYC);
    end
  end

  // Closed while either reset is high or a window is still running
  assign hif.hit_ok = (cnt == '0) && !hif.master_rst && !hif.partial_rst;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt       <= '0;
      mrst_prev <= 1'b0;
      prst_prev <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      mrst_prev <= hif.master_rst;
      prst_prev <= hif.partial_rst;
    end
  end

endmodule
`default_nettype wire

// ===== tb/ahbp_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ahbp_port_monitor #(
  parameter int DATA_W   = 28,
  parameter int NUM_HITS = 9
) (
  input wire logic                REF_CLK_IN,
  input wire logic                RST_IN,
  input wire logic                CHIP_SELECT_N_IN,
  input wire logic                READ_STROBE_N_IN,
  input wire logic                OUTPUT_HOLD_N_IN,
  input wire logic [3:0]          ADDR_IN,
  input wire logic [DATA_W-1:0]   DATA_IN,
  input wire logic [DATA_W-1:0]   DATA_OUT,
  input wire logic                DATA_OE_OUT,
  input wire logic                FIFO_A_POP_OUT,
  input wire logic                FIFO_B_POP_OUT,
  input wire logic                BUS16_OUT,
  input wire logic                MASTER_RESET_IN,
  input wire logic                PARTIAL_RESET_IN,
  input wire logic [NUM_HITS-1:0] HIT_IN,
  input wire logic [NUM_HITS-1:0] HIT_OUT
);
  logic [3:0] up;
  logic [3:0] next_up;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // Cycles since reset, saturating
  always_comb next_up = (up == 4'hF) ? up : up + 4'h1;
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) up <= RST_IN ? 4'h0 : next_up;
  oe_follow_a: assert property (
    up == 4'hF |-> DATA_OE_OUT == $past(!OUTPUT_HOLD_N_IN || (!CHIP_SELECT_N_IN && !READ_STROBE_N_IN), 3))
    else $error("bus enable wrong");
  cs_gate_a: assert property (
    CHIP_SELECT_N_IN [*6] |-> !FIFO_A_POP_OUT && !FIFO_B_POP_OUT) else $error("pop without select");
  pop_addr_a: assert property (
    FIFO_A_POP_OUT |-> $past(ADDR_IN, 3) == ahbp_pkg::ADDR_FIFO_A && !$past(CHIP_SELECT_N_IN, 3))
    else $error("pop from wrong access");
  mode_set_a: assert property (
    $rose(BUS16_OUT) |-> $past(ADDR_IN, 3) == ahbp_pkg::ADDR_MODE && $past(DATA_IN, 3) == ahbp_pkg::MODE16_VALUE)
    else $error("mode set without write");
  hi_zero_a: assert property (
    BUS16_OUT && $changed(DATA_OUT) |-> DATA_OUT[DATA_W-1:16] == '0) else $error("upper bits not zero");
  mrst_gate_a: assert property (
    MASTER_RESET_IN [*4] |-> HIT_OUT == '0) else $error("hit in master reset");
  prst_gate_a: assert property (
    PARTIAL_RESET_IN [*4] |-> HIT_OUT == '0) else $error("hit in partial reset");
  hit_pass_a: assert property (
    (up == 4'hF && !MASTER_RESET_IN && !PARTIAL_RESET_IN) [*8] |-> HIT_OUT == ($past(HIT_IN, 3) & ~$past(HIT_IN, 4)))
    else $error("hit not passed");
  cover property (FIFO_A_POP_OUT);
  cover property (BUS16_OUT && FIFO_B_POP_OUT);
  cover property (|HIT_OUT);
endmodule
bind ahbp_port ahbp_port_monitor #(.DATA_W(DATA_W), .NUM_HITS(NUM_HITS)) mon_u (
  .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN),
  .READ_STROBE_N_IN(READ_STROBE_N_IN), .OUTPUT_HOLD_N_IN(OUTPUT_HOLD_N_IN), .ADDR_IN(ADDR_IN),
  .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_OUT(DATA_OE_OUT), .FIFO_A_POP_OUT(FIFO_A_POP_OUT),
  .FIFO_B_POP_OUT(FIFO_B_POP_OUT), .BUS16_OUT(BUS16_OUT), .MASTER_RESET_IN(MASTER_RESET_IN),
  .PARTIAL_RESET_IN(PARTIAL_RESET_IN), .HIT_IN(HIT_IN), .HIT_OUT(HIT_OUT)
);
`default_nettype wire

// ===== tb/ahbp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ahbp_host_model (
  input  wire logic        clk,
  input  wire logic [27:0] bus,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             hold_n,
  output logic [3:0]       addr,
  output logic [27:0]      wdata,
  output logic             wen
);
  logic park_n = 1'b1;
  logic sel_n  = 1'b0;
  initial begin
    {cs_n, rd_n, wr_n, hold_n} = 4'hF;
    {addr, wdata, wen} = 33'h0;
  end
  // One strobe: 4 cycles low, 4 high; select, address and data held throughout
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [27:0] d, output logic [27:0] q);
    @(negedge clk);
    if (wr && !hold_n) begin
      hold_n = 1'b1;
      repeat (4) @(negedge clk);
    end
    cs_n = sel_n;
    addr = a;
    wen = wr;
    wdata = d;
    wr_n = !wr;
    rd_n = wr;
    repeat (4) @(negedge clk);
    q = bus;
    {wr_n, rd_n} = 2'h3; // Long high time lets empty settle, so no dummy read
    repeat (4) @(negedge clk);
    {cs_n, wen} = 2'h2;
    addr = ~a;
    wdata = ~d;
    hold_n = park_n;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mrst = 1'b0;
  logic        prst = 1'b0;
  logic        a_emp = 1'b1;
  logic        b_emp = 1'b1;
  logic [27:0] a_word = 28'h0;
  logic [27:0] b_word = 28'h0;
  logic [8:0]  hit = 9'h000;
  logic [8:0]  hit_out;
  logic [27:0] dout, wdata, bus, q, q1, d, e;
  logic        cs_n, rd_n, wr_n, hold_n, wen, oe, a_pop, b_pop, a_eo, b_eo, b16;
  logic [3:0]  addr, a;
  logic [8:0]  h;
  logic [27:0] qa[$];
  logic [27:0] qb[$];
  int          error_cnt = 0;
  int          n_checks = 0;
  int          hits = 0;
  int          n;
  int          seed = 32'h6dfea1c5;
  always #50 clk = ~clk;
  // Data pins pulled down when nobody drives
  assign bus = wen ? wdata : (oe ? dout : 28'h0);
  ahbp_host_model host_u (.clk(clk), .bus(bus), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .hold_n(hold_n), .addr(addr), .wdata(wdata), .wen(wen));
  ahbp_port dut_u (
    .REF_CLK_IN(clk), .RST_IN(rst), .CHIP_SELECT_N_IN(cs_n), .READ_STROBE_N_IN(rd_n),
    .WRITE_STROBE_N_IN(wr_n), .OUTPUT_HOLD_N_IN(hold_n), .ADDR_IN(addr), .DATA_IN(bus),
    .DATA_OUT(dout), .DATA_OE_OUT(oe), .FIFO_A_WORD_IN(a_word), .FIFO_A_EMPTY_IN(a_emp),
    .FIFO_A_POP_OUT(a_pop), .FIFO_A_EMPTY_OUT(a_eo), .FIFO_B_WORD_IN(b_word), .FIFO_B_EMPTY_IN(b_emp),
    .FIFO_B_POP_OUT(b_pop), .FIFO_B_EMPTY_OUT(b_eo), .BUS16_OUT(b16), .MASTER_RESET_IN(mrst),
    .PARTIAL_RESET_IN(prst), .HIT_IN(hit), .HIT_OUT(hit_out));
  // Result FIFO sources; an empty source shows a changing pattern
  always @(posedge clk) begin
    if (a_pop && qa.size() > 0) void'(qa.pop_front());
    if (b_pop && qb.size() > 0) void'(qb.pop_front());
    hits += $countones(hit_out);
  end
  always @(negedge clk) begin
    a_emp = (qa.size() == 0);
    b_emp = (qb.size() == 0);
    a_word = a_emp ? ~a_word : qa[0];
    b_word = b_emp ? ~b_word : qb[0];
  end
  task automatic chk(input string nm, input logic [27:0] got, input logic [27:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(4000 * 100);
    error_cnt++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("reset flags", {25'h0, b_eo, a_eo, b16}, 28'h0000006);
    for (int i = 0; i < 4; i++) begin
      a = 4'($random(seed)) & 4'h7;
      d = 28'($random(seed));
      host_u.xfer(1'b1, a, d, q);
      host_u.sel_n = (i == 3);
      host_u.xfer(1'b1, a, ~d, q);
      host_u.sel_n = 1'b0;
      host_u.xfer(1'b0, a, 28'h0, q);
      chk("register", q, (i == 3) ? d : ~d);
    end
    repeat (3) qa.push_back(28'($random(seed)));
    repeat (2) qb.push_back(28'($random(seed)));
    repeat (3) @(negedge clk);
    n = 0;
    while (a_eo === 1'b0 && n < 6) begin
      e = qa[0];
      host_u.xfer(1'b0, ahbp_pkg::ADDR_FIFO_A, 28'h0, q);
      chk("fifo a word", q, e);
      chk("enable idle", oe, 1'b0);
      n++;
    end
    chk("fifo a reads", n, 3);
    host_u.park_n = 1'b0;
    host_u.xfer(1'b1, ahbp_pkg::ADDR_MODE, ahbp_pkg::MODE16_VALUE, q);
    chk("bus16", b16, 1'b1);
    d = 28'($random(seed));
    host_u.xfer(1'b1, 4'h2, {12'h0, d[15:0]}, q);
    host_u.xfer(1'b1, 4'h2, {12'h0, d[27:12]}, q);
    host_u.xfer(1'b0, 4'h2, 28'h0, q);
    host_u.xfer(1'b0, 4'h2, 28'h0, q1);
    chk("lsw", q, {12'h0, d[15:0]});
    chk("msw", q1, {16'h0, d[23:12]});
    while (b_eo === 1'b0 && n < 9) begin
      e = qb[0];
      host_u.xfer(1'b0, ahbp_pkg::ADDR_FIFO_B, 28'h0, q);
      chk("fifo b empty", b_eo, qb.size() == 0);
      host_u.xfer(1'b0, ahbp_pkg::ADDR_FIFO_B, 28'h0, q1);
      chk("fifo b word", {q1[11:0], q[15:0]}, e);
      chk("enable held", oe, 1'b1);
      n++;
    end
    for (int r = 0; r < 3; r++) begin
      h = 9'($random(seed)) | 9'h001;
      n = hits;
      mrst = (r == 1);
      prst = (r == 2);
      repeat (2) @(negedge clk);
      hit = h;
      repeat (4) @(negedge clk);
      hit = 9'h000;
      mrst = 1'b0;
      prst = 1'b0;
      repeat (8) @(negedge clk);
      chk("hits", hits - n, (r == 0) ? $countones(h) : 0);
    end
    results();
  end
endmodule
`default_nettype wire
